/* hdl/soe_pkg.sv */
package soe_pkg;

	// Depth of one expander; cascades build multiples of this
	localparam int unsigned SOE_STAGES = 10;
	// Position of the stage that takes the serial input
	localparam int unsigned SOE_FIRST_STAGE = 0;
	// Position of the stage that feeds the serial output
	localparam int unsigned SOE_LAST_STAGE = SOE_STAGES - 1;
	// Register contents after power-on clear
	localparam logic [SOE_STAGES-1:0] SOE_CLEAR_VALUE = 10'h000;
	// Level shown on every parallel line while disabled
	localparam logic [SOE_STAGES-1:0] SOE_DISABLED_VALUE = 10'h000;
	// Level of the serial output after power-on clear
	localparam logic SOE_SERIAL_CLEAR = 1'h0;
	// Cycles from a sampled rising shift clock to the updated stages
	localparam int unsigned SOE_SHIFT_LATENCY = 2;
	// Cycles from a sampled enable change to the parallel lines
	localparam int unsigned SOE_ENABLE_LATENCY = 1;

endpackage : soe_pkg

/* hdl/soe_out_gate.sv */
`timescale 1ns/1ps

// Gated parallel output stage, one flip-flop per line
module soe_out_gate
	import soe_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic gate_enable,
	input wire logic [SOE_STAGES-1:0] stage_value,
	output logic [SOE_STAGES-1:0] gated_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Per-line gating and output flops

	genvar gi;
	generate
		for (gi = 0; gi < SOE_STAGES; gi++)
		begin : g_line
			logic line_nxt;
			logic line_r;

			// Disabled lines sit at logic 0 whatever the stage holds
			assign line_nxt = gate_enable ? stage_value[gi] : SOE_DISABLED_VALUE[gi];

			// Registered so the pins never glitch on an enable change
			always_ff @(posedge clk_sys)
			begin
				if (rst)
					line_r <= SOE_DISABLED_VALUE[gi];
				else
					line_r <= line_nxt;
			end

			assign gated_out[gi] = line_r;
		end
	endgenerate

endmodule : soe_out_gate

/* hdl/soe_shift10.sv */
`timescale 1ns/1ps

module soe_shift10
	import soe_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic shift_clock,
	input wire logic serial_in,
	input wire logic output_enable,
	output logic [SOE_STAGES-1:0] parallel_outputs,
	output logic serial_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic sclk_d1_r;
	logic sclk_d2_r;
	logic din_d1_r;
	logic [SOE_STAGES-1:0] shift_r;
	logic [SOE_STAGES-1:0] shift_nxt;
	logic serial_out_r;
	logic serial_out_nxt;
	logic shift_edge;

	////////////////////////////////////////////////////////////////////////////////
	// Input sampling

	// Clock goes through one more flop than data, so a bit that changes
	// with the rising edge is still the one taken
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sclk_d1_r <= 1'h0;
			sclk_d2_r <= 1'h0;
			din_d1_r <= 1'h0;
		end
		else
		begin
			sclk_d1_r <= shift_clock;
			sclk_d2_r <= sclk_d1_r;
			din_d1_r <= serial_in;
		end
	end

	// Rising edge of the delayed shift clock
	assign shift_edge = sclk_d1_r & ~sclk_d2_r;

	////////////////////////////////////////////////////////////////////////////////
	// Shift register

	// New bit lands in stage 0; the old top stage is dropped, the cascade gets the new top
	assign shift_nxt = shift_edge ? {shift_r[SOE_LAST_STAGE-1:SOE_FIRST_STAGE], din_d1_r} : shift_r;

	// Serial output follows the top stage in the same cycle as the lines
	assign serial_out_nxt = shift_nxt[SOE_LAST_STAGE];

	// Synchronous reset stands in for the power-on clear
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			shift_r <= SOE_CLEAR_VALUE;
			serial_out_r <= SOE_SERIAL_CLEAR;
		end
		else
		begin
			shift_r <= shift_nxt;
			serial_out_r <= serial_out_nxt;
		end
	end

	assign serial_out = serial_out_r;

	////////////////////////////////////////////////////////////////////////////////
	// Gated parallel outputs

	// Fed with the next value so lines and serial output move together
	soe_out_gate u_out_gate (
		.clk_sys(clk_sys),
		.rst(rst),
		.gate_enable(output_enable),
		.stage_value(shift_nxt),
		.gated_out(parallel_outputs)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	// One stage per detected edge, bit order upward
	a_shift_one_stage: assert property (
		@(posedge clk_sys) disable iff (rst)
		shift_edge |=> shift_r == {$past(shift_r[SOE_LAST_STAGE-1:SOE_FIRST_STAGE]), $past(din_d1_r)})
		else $error("shift did not move one stage upward");

	// Without an edge the register holds
	a_hold_no_edge: assert property (
		@(posedge clk_sys) disable iff (rst)
		!shift_edge |=> $stable(shift_r))
		else $error("register changed without a shift clock edge");

	// The bit present at the sampled clock rise is the one captured
	a_capture_race: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(shift_clock) |-> ##2 shift_r[SOE_FIRST_STAGE] == $past(serial_in, 2))
		else $error("serial bit at clock rise not captured");

	// A rising shift clock moves the old contents up within two cycles
	a_rise_shifts: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(shift_clock) |-> ##2 shift_r[SOE_LAST_STAGE:1] == $past(shift_r[SOE_LAST_STAGE-1:0], 1))
		else $error("rising shift clock did not shift the register");

	// Enabled lines show the stages
	a_enable_drive: assert property (
		@(posedge clk_sys) disable iff (rst)
		output_enable |=> parallel_outputs == shift_r)
		else $error("enabled parallel lines differ from the register");

	// Disabled lines sit at zero
	a_disable_zero: assert property (
		@(posedge clk_sys) disable iff (rst)
		!output_enable |=> parallel_outputs == SOE_DISABLED_VALUE)
		else $error("disabled parallel lines not at zero");

	// Serial output tracks the top stage even while disabled
	a_serial_tracks: assert property (
		@(posedge clk_sys) disable iff (rst)
		(!output_enable && shift_edge) |=> serial_out == $past(shift_r[SOE_LAST_STAGE-1]))
		else $error("serial output did not follow the top stage while disabled");

	// Serial output and top line come from separate flops; they must agree while enabled
	a_serial_top: assert property (
		@(posedge clk_sys) disable iff (rst)
		output_enable |=> serial_out == parallel_outputs[SOE_LAST_STAGE])
		else $error("serial output differs from the last stage");

	// Clear leaves everything at zero
	a_reset_clear: assert property (
		@(posedge clk_sys)
		rst |=> (shift_r == SOE_CLEAR_VALUE) && (parallel_outputs == SOE_DISABLED_VALUE) && !serial_out)
		else $error("reset did not clear the register and outputs");

	////////////////////////////////////////////////////////////////////////////////
	// Assertions on edge timing and on what the pins show
	// The line and serial checks look at the output flops, so a broken gate or cascade path is caught at the pins

	// A sampled rise opens the shift window on the next edge
	a_rise_to_edge: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(shift_clock) |=> shift_edge)
		else $error("sampled shift clock rise did not open the shift window");

	// One rise gives exactly one shift, never two
	a_edge_single: assert property (
		@(posedge clk_sys) disable iff (rst)
		shift_edge |=> !shift_edge)
		else $error("shift window stayed open for two cycles");

	// A falling shift clock moves nothing
	a_fall_no_shift: assert property (
		@(posedge clk_sys) disable iff (rst)
		$fell(shift_clock) |-> ##2 $stable(shift_r))
		else $error("register shifted on a falling shift clock");

	// A shift clock held high moves nothing
	a_high_level_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		(sclk_d1_r && shift_clock) |-> ##2 $stable(shift_r))
		else $error("register shifted while the shift clock stayed high");

	// Lines stand while neither a shift nor an enable change arrives
	a_lines_stable: assert property (
		@(posedge clk_sys) disable iff (rst)
		(!shift_edge && $stable(output_enable)) |=> $stable(parallel_outputs))
		else $error("parallel lines moved without a shift or enable change");

	// Serial output stands between shifts, whatever the enable does
	a_serial_stands: assert property (
		@(posedge clk_sys) disable iff (rst)
		!shift_edge |=> $stable(serial_out))
		else $error("serial output moved without a shift");

	// Cascade sees the old stage below the top on every shift, enabled or not
	a_cascade_bit: assert property (
		@(posedge clk_sys) disable iff (rst)
		shift_edge |=> serial_out == $past(shift_r[SOE_LAST_STAGE-1]))
		else $error("serial output did not take the stage below the top");

	// The captured bit shows on the lowest line
	a_first_line_bit: assert property (
		@(posedge clk_sys) disable iff (rst)
		(shift_edge && output_enable) |=> parallel_outputs[SOE_FIRST_STAGE] == $past(din_d1_r))
		else $error("new bit did not appear on the lowest parallel line");

	// Every enabled line hands its bit one line up
	a_lines_move_up: assert property (
		@(posedge clk_sys) disable iff (rst)
		(shift_edge && output_enable && $past(output_enable)) |=>
		parallel_outputs[SOE_LAST_STAGE:1] == $past(parallel_outputs[SOE_LAST_STAGE-1:0]))
		else $error("parallel lines did not move one line upward");

	// Clear also empties the edge detector, so no stray shift follows it
	a_reset_no_edge: assert property (
		@(posedge clk_sys)
		rst |=> !shift_edge)
		else $error("shift window open right after clear");

endmodule : soe_shift10

/* dv/soe_port_model.sv */
`timescale 1ns/1ps

// Software port lines: data with clock high, then clock low
module soe_port_model
(
	input wire logic clk_sys,
	input wire logic go,
	input wire logic bit_in,
	input wire logic en_in,
	output logic shift_clock,
	output logic serial_in,
	output logic output_enable,
	output logic busy
);
	logic [2:0] step_r = 3'h0;
	initial
	begin
		shift_clock = 1'h0;
		serial_in = 1'h0;
		output_enable = 1'h0;
	end
	assign busy = go | (step_r != 3'h0);
	// Data flips right after the capture edge, so a late sample is caught
	always @(posedge clk_sys)
	begin
		if (step_r == 3'h0 && go)
		begin
			serial_in <= bit_in;
			shift_clock <= 1'h1;
			output_enable <= en_in;
			step_r <= 3'h1;
		end
		else if (step_r != 3'h0)
			step_r <= (step_r == 3'h4) ? 3'h0 : step_r + 3'h1;
		if (step_r == 3'h1)
			serial_in <= ~serial_in;
		if (step_r == 3'h2)
			shift_clock <= 1'h0;
	end
endmodule : soe_port_model

/* dv/soe_shift10_tb.sv */
`timescale 1ns/1ps

module soe_shift10_tb
	import soe_pkg::*;
;
	typedef struct {int cyc; logic [SOE_STAGES-1:0] par; logic ser;} soe_note_t;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic go = 1'h0;
	logic bit_in = 1'h0;
	logic en_in = 1'h0;
	logic shift_clock, serial_in, output_enable, busy, serial_out;
	logic [SOE_STAGES-1:0] parallel_outputs;
	logic [SOE_STAGES-1:0] model_r = 10'h000;
	int cyc = 0;
	int err_count = 0;
	int total_checks = 0;
	soe_note_t q[$];
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	soe_shift10 uut (.clk_sys(clk_sys), .rst(rst), .shift_clock(shift_clock), .serial_in(serial_in),
		.output_enable(output_enable), .parallel_outputs(parallel_outputs), .serial_out(serial_out));
	soe_port_model prt (.clk_sys(clk_sys), .go(go), .bit_in(bit_in), .en_in(en_in), .shift_clock(shift_clock),
		.serial_in(serial_in), .output_enable(output_enable), .busy(busy));
	////////////////////////////////////////////////////////////////
	task automatic chk_par(input string what, input logic [SOE_STAGES-1:0] exp, input logic [SOE_STAGES-1:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_par
	task automatic chk_ser(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_ser
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// Bounded wait for the port to go idle and all notes to be checked
	task automatic wait_idle();
		int n = 0;
		while ((busy !== 1'h0 || q.size() != 0) && n < 100)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 100)
		begin
			err_count++;
			stop_test();
		end
	endtask : wait_idle
	// Result lands four edges after go: model, rise sample, two-cycle shift
	task automatic shift(input logic b, input logic e);
		wait_idle();
		go <= 1'h1;
		bit_in <= b;
		en_in <= e;
		model_r = {model_r[SOE_STAGES-2:0], b};
		q.push_back('{cyc + 5, e ? model_r : SOE_DISABLED_VALUE, model_r[SOE_LAST_STAGE]});
		@(posedge clk_sys);
		go <= 1'h0;
	endtask : shift
	task automatic do_reset(input int n);
		rst <= 1'h1;
		repeat (n) @(posedge clk_sys);
		rst <= 1'h0;
		model_r = SOE_CLEAR_VALUE;
		@(posedge clk_sys);
	endtask : do_reset
	// Watcher takes the oldest note when its cycle comes round
	initial forever
	begin
		@(posedge clk_sys);
		#1;
		while (q.size() != 0 && q[0].cyc == cyc)
		begin
			chk_par("parallel_outputs", q[0].par, parallel_outputs);
			chk_ser("serial_out", q[0].ser, serial_out);
			void'(q.pop_front());
		end
	end
	initial
	begin
		void'($urandom(32'h78e2));
		do_reset(8);
		shift(1'h1, 1'h1);
		repeat (14) shift(1'($urandom), 1'h1);
		wait_idle();
		$display("test clear and fill done");
		do_reset(2);
		shift(1'h1, 1'h1);
		repeat (10) shift(1'h0, 1'($urandom));
		wait_idle();
		$display("test reset and walking one done");
		stop_test();
	end
endmodule : soe_shift10_tb
